// *** hw/bcc_pkg.sv ***
// Shared constants and types for the cipher control block.
// Assumes one 20 MHz clock domain and a 32-bit AXI4-Lite master.
package bcc_pkg;
    // ==========================================
    // Register map
    localparam logic [7:0] ADDR_MAIN = 8'h00; // Main control
    localparam logic [7:0] ADDR_RST = 8'h04; // Reset control
    localparam logic [7:0] ADDR_STAT = 8'h08; // Lock and busy status
    localparam logic [31:0] MAIN_RESET = 32'h0000_4010; // Append and forward on
    localparam logic [31:0] MAIN_MASK = 32'h07ff_ffff; // Implemented bits
    localparam logic [31:0] RST_RESET = 32'h0000_0000;
    localparam logic [31:0] RST_MASK = 32'h0000_0003;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================
    // Field positions
    localparam int B_START = 0;
    localparam int B_LOCK = 1;
    localparam int B_IFCLR = 2;
    localparam int B_OFCLR = 3;
    localparam int B_MSG = 4;
    localparam int B_HDR = 5;
    localparam int B_HPRI = 6;
    localparam int B_MPRI = 7;
    localparam int B_SRC = 8;
    localparam int B_DMA = 9;
    localparam int B_KEY = 10;
    localparam int B_TAG = 12;
    localparam int B_MIC = 14;
    localparam int B_DEC = 15;
    localparam int B_MODE = 16;
    localparam int B_CTR = 19;
    localparam int B_CTS = 26;
    localparam int B_SRST = 0;
    localparam int B_AUTO = 1;
    localparam int B_BUSY = 0;
    localparam int B_HGNT = 1;
    localparam int B_MGNT = 2;
    localparam int B_MREQ = 3;
    // ==========================================
    // Sizes and counts
    localparam int FIFO_WIDTH = 32;
    localparam int FIFO_DEPTH = 8;
    localparam logic [6:0] CTR_MIN = 7'h10; // Below this, full width
    localparam logic [7:0] CTR_FULL = 8'h80; // Exponent 128
    // ==========================================
    // Types
    typedef enum logic [2:0] {
        MODE_ECB = 3'b000, MODE_CBC = 3'b001, MODE_CTR = 3'b010,
        MODE_RSV3 = 3'b011, MODE_RSV4 = 3'b100, MODE_CCM = 3'b101,
        MODE_MMO = 3'b110, MODE_BYPASS = 3'b111
    } bcc_mode_t;
    typedef enum logic [1:0] {
        GNT_NONE = 2'b00, GNT_HOST = 2'b01, GNT_MAC = 2'b10
    } bcc_gnt_t;
    // Decoded settings handed to the datapath
    typedef struct packed {
        logic cts_std; // 1: standard stealing
        logic [7:0] ctr_exp; // Counter wraps at 2**ctr_exp
        bcc_mode_t mode;
        logic mode_bad; // Reserved mode code
        logic decrypt; // Effective direction
        logic append; // Effective tag/hash append
        logic [4:0] tag_bytes;
        logic [5:0] key_bytes;
        logic key_bad;
        logic dma_en;
        logic dma_src; // 1: data via DMA
        logic mac_pri;
        logic host_pri;
        logic hdr_out; // Effective header output
        logic msg_out;
    } bcc_cfg_t;
endpackage

// *** hw/bcc_ctrl.sv ***
// Cipher control registers, lock arbiter and output FIFO.
// Assumes the engine, MAC requester and stream share mclk.
// Notes on behaviour
// - Stealing bit: 0 vendor, 1 standard.
// - Counter modulus 2^128 below 16, else 2^v.
// - Mode codes: ECB,CBC,CTR,rsv,rsv,CCM,MMO,bypass.
// - Direction bit, ignored in hash or bypass.
// - Append tag/hash; CCM decrypt or hash; resets one.
// - Tag length codes: 0,4,8,16 bytes.
// - Key codes: 16, 32, 24 bytes, reserved.
// - DMA enable and register-or-DMA source bit.
// - MAC requester priority bit, one high.
// - Host requester priority bit, one high.
// - CCM header output only when bit set.
// - Output stream reaches FIFO only when enabled.
// - Host lock write one requests, zero releases.
// - Auto engine reset after lock obtained.
// - Soft reset bit holds engine in reset.
// - Status flag shows host lock granted.
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// Output FIFO
module bcc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage words
        logic [PW-1:0] wp; // Write pointer
        logic [PW-1:0] rp; // Read pointer
        logic [CW-1:0] cnt; // Words held
        logic in_rdy; // Registered not-full
        logic out_vld; // Registered not-empty
    } bcc_fifo_st_t;
    bcc_fifo_st_t q;
    bcc_fifo_st_t n;
    logic push;
    logic pop;

    // Wrap for depths that are not a power of two
    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    assign push = in_valid && q.in_rdy;
    assign pop = q.out_vld && out_ready;
    assign in_ready = q.in_rdy;
    assign out_valid = q.out_vld;
    assign out_data = q.mem[q.rp];

    // Next state; flush overrides a same-cycle push
    always_comb begin
        n = q;
        if (push) begin
            n.mem[q.wp] = in_data;
            n.wp = bump(q.wp);
        end
        if (pop) begin
            n.rp = bump(q.rp);
        end
        n.cnt = q.cnt + CW'(push) - CW'(pop);
        if (flush) begin
            n.wp = '0;
            n.rp = '0;
            n.cnt = '0;
        end
        n.in_rdy = (n.cnt != FULL);
        n.out_vld = (n.cnt != '0);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end
endmodule // bcc_fifo

// ==========================================
// Top: register slave, arbiter, controls
module bcc_ctrl (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic eng_busy,
    input wire logic mac_lock_req,
    output bcc_pkg::bcc_cfg_t eng_cfg,
    output logic eng_start,
    output logic eng_reset,
    output logic ingress_fifo_flush,
    output logic host_lock_granted,
    output logic mac_lock_granted,
    input wire logic os_valid,
    input wire logic [31:0] os_data,
    output logic os_ready,
    output logic out_valid,
    output logic [31:0] out_data,
    input wire logic out_ready
);
    typedef struct packed {
        logic aw_rdy; // Address slot free
        logic w_rdy; // Data slot free
        logic [7:0] aw_addr; // Held write address
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] main; // Main control image
        logic [31:0] rst; // Reset control image
        bcc_pkg::bcc_gnt_t gnt; // Current lock owner
        logic start_p; // Start pulse
        logic if_p; // Ingress flush pulse
        logic of_p; // Egress flush pulse
        logic auto_p; // Auto reset pulse
        logic eng_rst;
        bcc_pkg::bcc_cfg_t cfg;
    } bcc_st_t;
    bcc_st_t q;
    bcc_st_t n;
    logic [1:0] rs_ff; // Reset release synchroniser
    logic rst_n;
    logic fifo_rdy;
    logic push;
    logic [31:0] v;

    // ==========================================
    // Helpers
    // Byte-lane merge for partial writes
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            wmerge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    // Settings decode from the main control image
    function automatic bcc_pkg::bcc_cfg_t decode(input logic [31:0] m);
        bcc_pkg::bcc_cfg_t c;
        bcc_pkg::bcc_mode_t md;
        md = bcc_pkg::bcc_mode_t'(m[bcc_pkg::B_MODE +: 3]);
        c.mode = md;
        c.mode_bad = (md == bcc_pkg::MODE_RSV3) || (md == bcc_pkg::MODE_RSV4);
        c.cts_std = m[bcc_pkg::B_CTS];
        // Small codes mean the full 128-bit counter
        c.ctr_exp = (m[bcc_pkg::B_CTR +: 7] < bcc_pkg::CTR_MIN) ? bcc_pkg::CTR_FULL
                  : {1'b0, m[bcc_pkg::B_CTR +: 7]};
        // Hashing and bypass have no direction
        c.decrypt = m[bcc_pkg::B_DEC] && (md != bcc_pkg::MODE_MMO)
                  && (md != bcc_pkg::MODE_BYPASS);
        c.append = m[bcc_pkg::B_MIC] && ((md == bcc_pkg::MODE_MMO)
                 || (md == bcc_pkg::MODE_CCM && m[bcc_pkg::B_DEC]));
        case (m[bcc_pkg::B_TAG +: 2])
            2'h0: c.tag_bytes = 5'h00;
            2'h1: c.tag_bytes = 5'h04;
            2'h2: c.tag_bytes = 5'h08;
            default: c.tag_bytes = 5'h10;
        endcase
        c.key_bad = 1'b0;
        case (m[bcc_pkg::B_KEY +: 2])
            2'h0: c.key_bytes = 6'h10;
            2'h1: c.key_bytes = 6'h20;
            2'h2: c.key_bytes = 6'h18;
            default: begin
                c.key_bytes = 6'h10;
                c.key_bad = 1'b1;
            end
        endcase
        c.dma_en = m[bcc_pkg::B_DMA];
        c.dma_src = m[bcc_pkg::B_SRC];
        c.mac_pri = m[bcc_pkg::B_MPRI];
        c.host_pri = m[bcc_pkg::B_HPRI];
        c.hdr_out = m[bcc_pkg::B_HDR] && (md == bcc_pkg::MODE_CCM);
        c.msg_out = m[bcc_pkg::B_MSG];
        decode = c;
    endfunction

    // ==========================================
    // Reset release
    // Asynchronous assert, two-flop synchronous release
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rs_ff <= 2'h0;
        end else begin
            rs_ff <= {rs_ff[0], 1'b1};
        end
    end
    assign rst_n = rs_ff[1];

    // ==========================================
    // Next-state logic
    always_comb begin
        n = q;
        v = '0;
        n.start_p = 1'b0;
        n.if_p = 1'b0;
        n.of_p = 1'b0;
        n.auto_p = 1'b0;
        // Address and data taken in either order
        if (s_axi_awvalid && q.aw_rdy) begin
            n.aw_rdy = 1'b0;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.w_rdy) begin
            n.w_rdy = 1'b0;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        // Both halves held: commit and answer
        if (!q.aw_rdy && !q.w_rdy && !q.bvalid) begin
            n.bvalid = 1'b1;
            n.bresp = bcc_pkg::RESP_OKAY;
            case (q.aw_addr)
                bcc_pkg::ADDR_MAIN: begin
                    // Reserved bits dropped, so they read zero
                    v = wmerge(q.main, q.wdata, q.wstrb) & bcc_pkg::MAIN_MASK;
                    n.main = v;
                    // Command bits never stick
                    n.main[bcc_pkg::B_START] = 1'b0;
                    n.main[bcc_pkg::B_IFCLR] = 1'b0;
                    n.main[bcc_pkg::B_OFCLR] = 1'b0;
                    // A start during busy or reset is dropped
                    n.start_p = v[bcc_pkg::B_START] && !eng_busy
                              && !q.rst[bcc_pkg::B_SRST];
                    n.if_p = v[bcc_pkg::B_IFCLR];
                    n.of_p = v[bcc_pkg::B_OFCLR];
                end
                bcc_pkg::ADDR_RST: begin
                    n.rst = wmerge(q.rst, q.wdata, q.wstrb) & bcc_pkg::RST_MASK;
                end
                bcc_pkg::ADDR_STAT: begin
                    // Read-only: write ignored
                end
                default: begin
                    n.bresp = bcc_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (q.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
            n.aw_rdy = 1'b1;
            n.w_rdy = 1'b1;
        end
        // Read path, one outstanding
        if (s_axi_arvalid && q.ar_rdy) begin
            n.ar_rdy = 1'b0;
            n.rvalid = 1'b1;
            n.rresp = bcc_pkg::RESP_OKAY;
            n.rdata = '0;
            case (s_axi_araddr)
                bcc_pkg::ADDR_MAIN: n.rdata = q.main;
                bcc_pkg::ADDR_RST: n.rdata = q.rst;
                bcc_pkg::ADDR_STAT: begin
                    n.rdata[bcc_pkg::B_BUSY] = eng_busy;
                    n.rdata[bcc_pkg::B_HGNT] = (q.gnt == bcc_pkg::GNT_HOST);
                    n.rdata[bcc_pkg::B_MGNT] = (q.gnt == bcc_pkg::GNT_MAC);
                    n.rdata[bcc_pkg::B_MREQ] = mac_lock_req;
                end
                default: n.rresp = bcc_pkg::RESP_SLVERR;
            endcase
        end
        if (q.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
            n.ar_rdy = 1'b1;
        end
        // Lock arbiter: no preemption once granted
        case (q.gnt)
            bcc_pkg::GNT_NONE: begin
                // Tie goes to the host unless only the MAC priority bit is set
                if (q.main[bcc_pkg::B_LOCK] && mac_lock_req) begin
                    n.gnt = (q.cfg.mac_pri && !q.cfg.host_pri) ? bcc_pkg::GNT_MAC
                          : bcc_pkg::GNT_HOST;
                end else if (q.main[bcc_pkg::B_LOCK]) begin
                    n.gnt = bcc_pkg::GNT_HOST;
                end else if (mac_lock_req) begin
                    n.gnt = bcc_pkg::GNT_MAC;
                end
            end
            bcc_pkg::GNT_HOST: begin
                if (!q.main[bcc_pkg::B_LOCK]) begin
                    n.gnt = bcc_pkg::GNT_NONE;
                end
            end
            bcc_pkg::GNT_MAC: begin
                if (!mac_lock_req) begin
                    n.gnt = bcc_pkg::GNT_NONE;
                end
            end
            default: n.gnt = bcc_pkg::GNT_NONE;
        endcase
        // One-cycle engine reset on a fresh grant
        n.auto_p = q.rst[bcc_pkg::B_AUTO] && (q.gnt == bcc_pkg::GNT_NONE)
                 && (n.gnt != bcc_pkg::GNT_NONE);
        n.eng_rst = n.rst[bcc_pkg::B_SRST] || n.auto_p;
        n.cfg = decode(n.main);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.aw_rdy <= 1'b1;
            q.w_rdy <= 1'b1;
            q.ar_rdy <= 1'b1;
            q.main <= bcc_pkg::MAIN_RESET;
            q.rst <= bcc_pkg::RST_RESET;
            q.cfg <= decode(bcc_pkg::MAIN_RESET);
        end else begin
            q <= n;
        end
    end

    // ==========================================
    // Output stream path
    // Blocked stream is drained and dropped so the engine never hangs
    assign push = os_valid && fifo_rdy && q.cfg.msg_out;
    assign os_ready = q.cfg.msg_out ? fifo_rdy : 1'b1;

    bcc_fifo #(
        .WIDTH(bcc_pkg::FIFO_WIDTH),
        .DEPTH(bcc_pkg::FIFO_DEPTH)
    ) u_egress (
        .mclk(mclk),
        .rst_n(rst_n),
        .flush(q.of_p),
        .in_valid(push),
        .in_data(os_data),
        .in_ready(fifo_rdy),
        .out_valid(out_valid),
        .out_data(out_data),
        .out_ready(out_ready)
    );

    assign s_axi_awready = q.aw_rdy;
    assign s_axi_wready = q.w_rdy;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.ar_rdy;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign eng_cfg = q.cfg;
    assign eng_start = q.start_p;
    assign eng_reset = q.eng_rst;
    assign ingress_fifo_flush = q.if_p;
    assign host_lock_granted = (q.gnt == bcc_pkg::GNT_HOST);
    assign mac_lock_granted = (q.gnt == bcc_pkg::GNT_MAC);

    // ==========================================
    // Assertions
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    host_grant_a: assert property ((q.main[bcc_pkg::B_LOCK] && !mac_lock_req && q.gnt == bcc_pkg::GNT_NONE)
        |=> host_lock_granted) else $error("host lock not granted");
    release_a: assert property ((host_lock_granted && !q.main[bcc_pkg::B_LOCK])
        |=> !host_lock_granted) else $error("host lock not released");
    soft_reset_a: assert property (q.rst[bcc_pkg::B_SRST] |-> eng_reset)
        else $error("engine left out of reset");
    auto_reset_a: assert property (($past(q.gnt) == bcc_pkg::GNT_NONE && q.gnt != bcc_pkg::GNT_NONE
        && $past(q.rst[bcc_pkg::B_AUTO])) |-> eng_reset) else $error("no auto reset");
    start_busy_a: assert property (eng_busy |=> !eng_start)
        else $error("start while busy");
    ctr_full_a: assert property ((q.main[bcc_pkg::B_CTR +: 7] < 7'h10) |-> eng_cfg.ctr_exp == 8'h80)
        else $error("counter modulus wrong");
    dir_ignore_a: assert property ((q.main[bcc_pkg::B_MODE +: 3] inside {3'h6, 3'h7})
        |-> !eng_cfg.decrypt) else $error("direction not ignored");
    key_size_a: assert property ((q.main[bcc_pkg::B_KEY +: 2] == 2'h2) |-> eng_cfg.key_bytes == 6'h18)
        else $error("key size wrong");
    msg_block_a: assert property (!q.cfg.msg_out |-> !push)
        else $error("blocked stream entered fifo");
    egress_flush_a: assert property (q.of_p |=> !out_valid)
        else $error("fifo not flushed");
    host_gnt_c: cover property (host_lock_granted ##1 !host_lock_granted);
    mac_gnt_c: cover property (mac_lock_granted && q.main[bcc_pkg::B_LOCK]);
    fifo_full_c: cover property (!fifo_rdy && q.cfg.msg_out);
    auto_rst_c: cover property (q.auto_p);
endmodule // bcc_ctrl

`default_nettype wire

// *** verification/bcc_partner.sv ***
// Far side: engine busy, MAC lock requester, stream source and sink.
// Assumes one clock, mclk; the bench commands each behaviour.
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// Partner model
module bcc_partner (
    input wire logic mclk,
    input wire logic busy_cmd,
    input wire logic mac_cmd,
    input wire logic [7:0] push_req,
    input wire logic drain,
    input wire logic os_ready,
    output logic eng_busy,
    output logic mac_lock_req,
    output logic os_valid,
    output logic [31:0] os_data,
    output logic out_ready
);
    logic [7:0] sent_ff = 8'h00; // Words already taken by the block
    // Engine busy level and MAC lock request as commanded
    assign eng_busy = busy_cmd;
    assign mac_lock_req = mac_cmd;
    // Sink stalls unless the bench lets it drain
    assign out_ready = drain;
    // Source offers words until the bench's quota is met
    assign os_valid = (sent_ff != push_req);
    // Idle data shows the inverse so stale values never pass
    assign os_data = os_valid ? {24'hc0de00, sent_ff} : ~{24'hc0de00, sent_ff};
    // Advance only on a real handshake
    always_ff @(posedge mclk) begin
        if (os_valid && os_ready) begin
            sent_ff <= sent_ff + 8'h01;
        end
    end
endmodule // bcc_partner
`default_nettype wire

// *** verification/block_cipher_control_regs_tb.sv ***
// Self-checking bench for the cipher control block.
// Assumes the partner model drives the engine and MAC side.
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// Bench top
module block_cipher_control_regs_tb;
    typedef struct packed {
        logic [31:0] wd; // Main control word
        logic [2:0] m; // Expected mode
        logic d; // Expected direction
        logic a; // Expected append
        logic h; // Expected header output
        logic [4:0] t; // Tag bytes
        logic [5:0] k; // Key bytes
        logic [7:0] c; // Counter exponent
    } bcc_row_t;
    localparam bcc_row_t ROWS [11] = '{ // Reserved bits all zero
        '{32'h0400_4000, 3'h0, 1'b0, 1'b0, 1'b0, 5'h00, 6'h10, 8'h80},
        '{32'h0401_9400, 3'h1, 1'b1, 1'b0, 1'b0, 5'h04, 6'h20, 8'h80},
        '{32'h007a_2800, 3'h2, 1'b0, 1'b0, 1'b0, 5'h08, 6'h18, 8'h80},
        '{32'h0082_3000, 3'h2, 1'b0, 1'b0, 1'b0, 5'h10, 6'h10, 8'h10},
        '{32'h03fd_c020, 3'h5, 1'b1, 1'b1, 1'b1, 5'h00, 6'h10, 8'h7f},
        '{32'h0006_c000, 3'h6, 1'b0, 1'b1, 1'b0, 5'h00, 6'h10, 8'h80},
        '{32'h0007_4020, 3'h7, 1'b0, 1'b0, 1'b0, 5'h00, 6'h10, 8'h80},
        '{32'h0005_4020, 3'h5, 1'b0, 1'b0, 1'b1, 5'h00, 6'h10, 8'h80},
        '{32'h0000_03c0, 3'h0, 1'b0, 1'b0, 1'b0, 5'h00, 6'h10, 8'h80},
        '{32'h0004_4010, 3'h4, 1'b0, 1'b0, 1'b0, 5'h00, 6'h10, 8'h80},
        '{32'h0003_4c10, 3'h3, 1'b0, 1'b0, 1'b0, 5'h00, 6'h10, 8'h80}
    };
    localparam logic [7:0] A_MAIN = bcc_pkg::ADDR_MAIN, A_RST = bcc_pkg::ADDR_RST;
    bcc_row_t r; // Row under test
    logic mclk = 1'b0, resetn = 1'b0, er_q = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, os_data, out_data, rd;
    logic [3:0] s_axi_wstrb = 4'hf; // Whole words only
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    bcc_pkg::bcc_cfg_t eng_cfg;
    logic eng_busy, mac_lock_req, eng_start, eng_reset, ingress_fifo_flush;
    logic host_lock_granted, mac_lock_granted, os_valid, os_ready, out_valid, out_ready;
    logic busy_cmd = 1'b0, mac_cmd = 1'b0, drain = 1'b0;
    logic [7:0] push_req = 8'h00, rx = 8'h00;
    int miscompares = 0, n_tests = 0, n_start = 0, n_rst = 0, n_ifl = 0;

    bcc_ctrl dut (.*);
    bcc_partner far (.*);

    // ==========================================
    // Clock, watchdog and monitors
    initial begin
        forever #25 mclk = ~mclk;
    end
    initial begin
        #2000000;
        miscompares++;
        finish_test();
    end
    // Pulse counters and in-order check of drained words
    always @(posedge mclk) begin
        if (eng_start === 1'b1) n_start++;
        if (ingress_fifo_flush === 1'b1) n_ifl++;
        if (eng_reset === 1'b1 && er_q !== 1'b1) n_rst++;
        er_q <= eng_reset;
        if (out_valid === 1'b1 && out_ready) begin
            chk("out_data", {24'hc0de00, rx}, out_data);
            rx <= rx + 8'h01;
        end
    end

    // ==========================================
    // Tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // AXI4-Lite write; waits for the response however long it takes
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // AXI4-Lite read into rd and rsp
    task automatic rdr(input logic [7:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Let n edges pass, then sample settled outputs
    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        wait_n(3);
        chk("msg_out at reset", 1, eng_cfg.msg_out);
        rdr(A_MAIN);
        chk("main reset", 32'h0000_4010, rd);
        rdr(A_RST);
        chk("reset reg reset", 0, rd);
        rdr(8'h0c);
        chk("unmapped resp", bcc_pkg::RESP_SLVERR, rsp);
        // Decode table, one row per setting combination
        foreach (ROWS[i]) begin
            r = ROWS[i];
            wr(A_MAIN, r.wd);
            chk("bresp", bcc_pkg::RESP_OKAY, rsp);
            wait_n(1);
            chk("mode", r.m, eng_cfg.mode);
            chk("mode_bad", r.m inside {3'h3, 3'h4}, eng_cfg.mode_bad);
            chk("decrypt", r.d, eng_cfg.decrypt);
            chk("append", r.a, eng_cfg.append);
            chk("hdr_out", r.h, eng_cfg.hdr_out);
            chk("tag_bytes", r.t, eng_cfg.tag_bytes);
            chk("key_bytes", r.k, eng_cfg.key_bytes);
            chk("key_bad", r.wd[11:10] == 2'h3, eng_cfg.key_bad);
            chk("ctr_exp", r.c, eng_cfg.ctr_exp);
            chk("cts_std", r.wd[26], eng_cfg.cts_std);
            chk("dma", r.wd[9:8], {eng_cfg.dma_en, eng_cfg.dma_src});
            chk("mac_pri", r.wd[7], eng_cfg.mac_pri);
            chk("host_pri", r.wd[6], eng_cfg.host_pri);
            chk("msg_out", r.wd[4], eng_cfg.msg_out);
            rdr(A_MAIN);
            chk("main readback", r.wd & 32'h07ff_fff2, rd);
        end
        // Start pulse, then a start refused while busy
        wr(A_MAIN, 32'h0000_4011);
        wait_n(3);
        chk("start count", 1, n_start);
        @(posedge mclk);
        busy_cmd <= 1'b1;
        wr(A_MAIN, 32'h0000_4011);
        wait_n(3);
        chk("start while busy", 1, n_start);
        @(posedge mclk);
        busy_cmd <= 1'b0;
        wr(A_MAIN, 32'h0000_4014);
        wait_n(3);
        chk("ingress flush", 1, n_ifl);
        // Soft reset holds the engine and blocks start
        wr(A_RST, 32'h1);
        wr(A_MAIN, 32'h0000_4011);
        wait_n(3);
        chk("reset level", 1, eng_reset);
        chk("start in reset", 1, n_start);
        wr(A_RST, 32'h0);
        wait_n(2);
        chk("reset released", 0, eng_reset);
        // Host lock with automatic engine reset
        wr(A_RST, 32'h2);
        wr(A_MAIN, 32'h0000_4012);
        wait_n(3);
        chk("host grant", 1, host_lock_granted);
        chk("auto reset", 2, n_rst);
        rdr(bcc_pkg::ADDR_STAT);
        chk("status host lock", 1, rd[1]);
        wr(A_MAIN, 32'h0000_4090);
        wait_n(2);
        chk("host release", 0, host_lock_granted);
        // MAC holds the lock; host waits until it lets go
        @(posedge mclk);
        mac_cmd <= 1'b1;
        wait_n(3);
        chk("mac grant", 1, mac_lock_granted);
        chk("auto reset mac", 3, n_rst);
        wr(A_MAIN, 32'h0000_4092);
        wait_n(3);
        chk("host blocked", 0, host_lock_granted);
        // MAC drops for one cycle and asks again: both ask, MAC has priority
        @(posedge mclk);
        mac_cmd <= 1'b0;
        @(posedge mclk);
        mac_cmd <= 1'b1;
        wait_n(2);
        chk("mac wins tie", 1, mac_lock_granted);
        @(posedge mclk);
        mac_cmd <= 1'b0;
        wait_n(3);
        chk("host after mac", 1, host_lock_granted);
        wr(A_RST, 32'h0);
        wr(A_MAIN, 32'h0000_4010);
        // Fill the output FIFO until it refuses, then drain it
        @(posedge mclk);
        push_req <= 8'h09;
        wait_n(20);
        chk("fifo full refuses", 0, os_ready);
        @(posedge mclk);
        drain <= 1'b1;
        wait_n(20);
        chk("drained words", 9, rx);
        chk("fifo empty", 0, out_valid);
        @(posedge mclk);
        drain <= 1'b0;
        push_req <= 8'h0c;
        wait_n(10);
        chk("fifo holds", 1, out_valid);
        wr(A_MAIN, 32'h0000_4018);
        wait_n(2);
        chk("egress flush", 0, out_valid);
        // Blocked output stream never reaches the FIFO
        wr(A_MAIN, 32'h0000_4000);
        @(posedge mclk);
        push_req <= 8'h0e;
        wait_n(10);
        chk("blocked stream", 0, out_valid);
        chk("blocked ready", 1, os_ready);
        finish_test();
    end
endmodule // block_cipher_control_regs_tb
`default_nettype wire
